// *** hdl/fpm_key_if.sv ***
`timescale 1ns/1ps
interface fpm_key_if #(parameter int unsigned N = 6);
  logic [N-1:0] held;
  logic [N-1:0] pressed;
  modport src (output held, output pressed);
  modport dst (input held, input pressed);
endinterface : fpm_key_if

// *** hdl/fpm_keys.sv ***
`timescale 1ns/1ps
module fpm_keys #(
  parameter int unsigned N = 6
) (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rstn,
  // raw key pins, low while pressed
  input  wire logic [N-1:0] key_pin_n,
  // filtered keys toward the menu logic
  fpm_key_if.src     keys
);
  import fpm_pkg::*;

  // three-stage capture per key, a level change needs stages two and three to agree
  for (genvar k = 0; k < N; k++) begin : g_key
    logic s1_q, s2_q, s3_q, lvl_q, prs_q;
    logic s1_d, s2_d, s3_d, lvl_d, prs_d;

    always_comb begin
      s1_d  = ~key_pin_n[k];
      s2_d  = s1_q;
      s3_d  = s2_q;
      lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
      prs_d = lvl_d & ~lvl_q;       // one pulse on the press edge
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        s1_q  <= 1'b0;
        s2_q  <= 1'b0;
        s3_q  <= 1'b0;
        lvl_q <= 1'b0;
        prs_q <= 1'b0;
      end else begin
        s1_q  <= s1_d;
        s2_q  <= s2_d;
        s3_q  <= s3_d;
        lvl_q <= lvl_d;
        prs_q <= prs_d;
      end
    end

    assign keys.held[k]    = lvl_q;
    assign keys.pressed[k] = prs_q;
  end

endmodule : fpm_keys

// *** hdl/fpm_menu.sv ***
`timescale 1ns/1ps
// What this block does
// R01: three five-digit signed passwords guard menus, defaults 00001, 00002, 00003.
// R02: level one opens user setup, two adds calibration, three adds configuration.
// R03: setup held one second in run mode opens level prompt showing level one.
// R04: up and down step the shown level among one, two and three.
// R05: limits latches level and opens password entry at zero, cursor rightmost.
// R06: other number entry starts from the stored value, cursor rightmost.
// R07: up and down change a non-leading flashing digit within 0 to 9.
// R08: enter accepts the digit and moves the cursor one place left.
// R09: reset alone restores the original value and cursor; only way rightward.
// R10: leading digit carries the sign and moves between -9 and +9.
// R11: enter with leading digit flashing commits the whole value.
// R12: enter plus reset together with any other digit flashing commits at once.
// R13: a commit stores the value, enters the menu and shows its next item.
// R14: a wrong password abandons access and returns to run mode.
// R15: in a menu up and down step items; enter opens the shown item.
// R16: a digit at its limit stays put instead of wrapping.
module fpm_menu #(
  parameter int unsigned HOLD_CYCLES = fpm_pkg::HOLD_CYCLES,
  parameter int unsigned ITEMS       = fpm_pkg::ITEMS
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // front-panel key pins, low while pressed
  input  wire logic [fpm_pkg::KEY_N-1:0]  key_pin_n,
  // display and mode
  output logic [4:0]                      mode_q,
  output logic [1:0]                      level_q,
  output fpm_pkg::fpm_num_t               disp_q,
  output logic [2:0]                      cursor_q,
  output logic [1:0]                      menu_q,
  output logic [$clog2(ITEMS)-1:0]        item_q,
  // store and access events
  output logic                            store_q,
  output logic                            denied_q
);
  import fpm_pkg::*;

  localparam int unsigned IW     = $clog2(ITEMS);
  localparam int unsigned HOLD_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [IW-1:0] ITEM_LAST = IW'(ITEMS - 1);

  fpm_key_if #(.N(KEY_N)) keys ();

  fpm_keys #(.N(KEY_N)) u_keys (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .key_pin_n (key_pin_n),
    .keys      (keys)
  );

  fpm_state_t          state_q, state_d;
  logic [HOLD_W-1:0]   hold_q, hold_d;
  logic [1:0]          level_d, top_q, top_d, menu_d;
  logic [IW-1:0]       item_d;
  fpm_num_t            disp_d, orig_q, orig_d;
  logic [2:0]          cursor_d;
  logic                is_pw_q, is_pw_d, store_d, denied_d;
  fpm_num_t            pw_q [3];
  fpm_num_t            par_q [MENU_N][ITEMS];
  fpm_num_t            par_d;

  // one digit step with clamping; the leading digit walks a signed range
  function automatic fpm_num_t step_digit(fpm_num_t v, logic [2:0] pos, logic up);
    fpm_num_t r;
    r = v;
    if (pos != POS_MSD) begin
      if (up && v.dig[pos] != DIG_MAX) r.dig[pos] = v.dig[pos] + 4'h1;      // [R07] [R16]
      if (!up && v.dig[pos] != DIG_MIN) r.dig[pos] = v.dig[pos] - 4'h1;     // [R07] [R16]
    end else if (up) begin
      if (v.neg && v.dig[pos] == 4'h1) r = '{neg: 1'b0, dig: v.dig & 20'h0_FFFF}; // [R10]
      else if (v.neg) r.dig[pos] = v.dig[pos] - 4'h1;                      // [R10]
      else if (v.dig[pos] != DIG_MAX) r.dig[pos] = v.dig[pos] + 4'h1;     // [R10] [R16]
    end else begin
      if (!v.neg && v.dig[pos] == DIG_MIN) begin
        r.neg      = 1'b1;                                                  // [R10]
        r.dig[pos] = 4'h1;
      end else if (!v.neg) r.dig[pos] = v.dig[pos] - 4'h1;                 // [R10]
      else if (v.dig[pos] != DIG_MAX) r.dig[pos] = v.dig[pos] + 4'h1;     // [R10] [R16]
    end
    return r;
  endfunction : step_digit

  // key decode used by the entry states
  logic k_up, k_dn, k_ent, k_rst, k_lim, k_set, both, commit, pw_ok;
  always_comb begin
    k_up   = keys.pressed[KEY_UP];
    k_dn   = keys.pressed[KEY_DOWN];
    k_lim  = keys.pressed[KEY_LIMITS];
    k_set  = keys.held[KEY_SETUP];
    // the two keys never land in one cycle by hand, so the later press decides
    both   = (keys.pressed[KEY_ENTER] & keys.held[KEY_RESET])
           | (keys.pressed[KEY_RESET] & keys.held[KEY_ENTER]);                // [R12]
    k_ent  = keys.pressed[KEY_ENTER] & ~keys.held[KEY_RESET];
    k_rst  = keys.pressed[KEY_RESET] & ~keys.held[KEY_ENTER];
    commit = both | (k_ent && cursor_q == POS_MSD);                          // [R11] [R12]
    pw_ok  = (disp_q == pw_q[level_q - 2'h1]);                               // [R14]
  end

  // next-state logic for mode, entry field and menu position
  always_comb begin
    state_d  = state_q;
    hold_d   = '0;
    level_d  = level_q;
    top_d    = top_q;
    menu_d   = menu_q;
    item_d   = item_q;
    disp_d   = disp_q;
    orig_d   = orig_q;
    cursor_d = cursor_q;
    is_pw_d  = is_pw_q;
    store_d  = 1'b0;
    denied_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        // release restarts the count, so the hold must be continuous
        if (k_set) hold_d = hold_q + HOLD_W'(1);                             // [R03]
        if (k_set && hold_q == HOLD_W'(HOLD_CYCLES - 1)) begin
          state_d = ST_LEVEL;                                                // [R03]
          level_d = LEVEL_ONE;                                               // [R03]
        end
      end
      ST_LEVEL: begin
        if (k_up && level_q != LEVEL_THREE) level_d = level_q + 2'h1;       // [R04]
        else if (k_dn && level_q != LEVEL_ONE) level_d = level_q - 2'h1;    // [R04]
        else if (k_lim) begin
          state_d  = ST_ENTRY;                                               // [R05]
          disp_d   = NUM_ZERO;                                               // [R05]
          orig_d   = NUM_ZERO;
          cursor_d = POS_LSD;                                                // [R05]
          is_pw_d  = 1'b1;
        end
      end
      ST_ENTRY: begin
        if (commit) begin
          if (is_pw_q && !pw_ok) begin
            state_d  = ST_RUN;                                               // [R14]
            denied_d = 1'b1;
          end else if (is_pw_q) begin
            state_d = ST_MENU;                                               // [R13]
            menu_d  = level_q - 2'h1;                                        // [R02]
            top_d   = level_q - 2'h1;                                        // [R02]
            item_d  = '0;
          end else begin
            state_d = ST_MENU;                                               // [R13]
            store_d = 1'b1;                                                  // [R13]
            if (item_q != ITEM_LAST) item_d = item_q + IW'(1);               // [R13]
            else if (menu_q != MENU_USER) begin
              menu_d = menu_q - 2'h1;                                        // [R02]
              item_d = '0;
            end
          end
        end else if (k_ent) cursor_d = cursor_q + 3'h1;                      // [R08]
        else if (k_rst) begin
          disp_d   = orig_q;                                                 // [R09]
          cursor_d = POS_LSD;                                                // [R09]
        end else if (k_up || k_dn) disp_d = step_digit(disp_q, cursor_q, k_up);
      end
      ST_MENU: begin
        // down walks forward, configuration flows into calibration then user setup
        if (k_dn) begin
          if (item_q != ITEM_LAST) item_d = item_q + IW'(1);                 // [R15]
          else if (menu_q != MENU_USER) begin
            menu_d = menu_q - 2'h1;                                          // [R02] [R15]
            item_d = '0;
          end
        end else if (k_up) begin
          if (item_q != '0) item_d = item_q - IW'(1);                        // [R15]
          else if (menu_q != top_q) begin
            menu_d = menu_q + 2'h1;                                          // [R15]
            item_d = ITEM_LAST;
          end
        end else if (k_ent) begin
          state_d  = ST_ENTRY;                                               // [R15]
          disp_d   = par_q[menu_q][item_q];                                  // [R06]
          orig_d   = par_q[menu_q][item_q];                                  // [R06]
          cursor_d = POS_LSD;                                                // [R06]
          is_pw_d  = 1'b0;
        end else if (k_rst) state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  // registers for mode, entry field and menu position
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q  <= ST_RUN;
      hold_q   <= '0;
      level_q  <= LEVEL_ONE;
      top_q    <= MENU_USER;
      menu_q   <= MENU_USER;
      item_q   <= '0;
      disp_q   <= NUM_ZERO;
      orig_q   <= NUM_ZERO;
      cursor_q <= POS_LSD;
      is_pw_q  <= 1'b0;
      store_q  <= 1'b0;
      denied_q <= 1'b0;
      mode_q   <= ST_RUN;
    end else begin
      state_q  <= state_d;
      hold_q   <= hold_d;
      level_q  <= level_d;
      top_q    <= top_d;
      menu_q   <= menu_d;
      item_q   <= item_d;
      disp_q   <= disp_d;
      orig_q   <= orig_d;
      cursor_q <= cursor_d;
      is_pw_q  <= is_pw_d;
      store_q  <= store_d;
      denied_q <= denied_d;
      mode_q   <= state_d;
    end
  end

  // stored settings; item editing of passwords is outside this block, so they hold defaults
  always_comb begin
    par_d = disp_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pw_q[0] <= PW_LEVEL_ONE_RST;                                          // [R01]
      pw_q[1] <= PW_LEVEL_TWO_RST;                                          // [R01]
      pw_q[2] <= PW_LEVEL_THREE_RST;                                        // [R01]
      for (int m = 0; m < MENU_N; m++) begin
        for (int i = 0; i < ITEMS; i++) par_q[m][i] <= NUM_ZERO;
      end
    end else if (state_q == ST_ENTRY && commit && !is_pw_q) begin
      par_q[menu_q][item_q] <= par_d;                                       // [R13]
    end
  end

  // check-side count of continuous setup hold, saturating at the full span
  // kept apart from hold_q so a miscounting design counter cannot vouch for itself
  logic [HOLD_W-1:0]   setup_run_q, setup_run_d;
  always_comb begin
    setup_run_d = '0;
    if (k_set && setup_run_q != HOLD_W'(HOLD_CYCLES)) setup_run_d = setup_run_q + HOLD_W'(1);
    else if (k_set) setup_run_d = setup_run_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) setup_run_q <= '0;
    else setup_run_q <= setup_run_d;
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_pw_table: assert property ( // [R01]
    pw_q[0] == PW_LEVEL_ONE_RST && pw_q[1] == PW_LEVEL_TWO_RST
    && pw_q[2] == PW_LEVEL_THREE_RST)
    else $error("password table changed");
  chk_level_open: assert property ( // [R03]
    state_q == ST_RUN ##1 state_q == ST_LEVEL |-> level_q == LEVEL_ONE && $past(k_set))
    else $error("level prompt opened wrongly");
  chk_level_step: assert property ( // [R04]
    state_q == ST_LEVEL && k_up && level_q == LEVEL_ONE |=> level_q == 2'h2)
    else $error("level did not step up");
  chk_pw_prompt: assert property ( // [R05]
    state_q == ST_LEVEL && k_lim && !k_up && !k_dn
    |=> state_q == ST_ENTRY && disp_q == NUM_ZERO && cursor_q == POS_LSD && is_pw_q)
    else $error("password prompt not zero");
  chk_digit_range: assert property ( // [R07]
    disp_q.dig[0] <= DIG_MAX && disp_q.dig[1] <= DIG_MAX && disp_q.dig[2] <= DIG_MAX
    && disp_q.dig[3] <= DIG_MAX && disp_q.dig[4] <= DIG_MAX)
    else $error("digit out of range");
  chk_cursor_left: assert property ( // [R08]
    state_q == ST_ENTRY && k_ent && cursor_q != POS_MSD |=> cursor_q == $past(cursor_q) + 3'h1)
    else $error("cursor did not move left");
  chk_reset_restore: assert property ( // [R09]
    state_q == ST_ENTRY && k_rst |=> cursor_q == POS_LSD && disp_q == orig_q)
    else $error("reset did not restore entry");
  chk_msd_commit: assert property ( // [R11]
    state_q == ST_ENTRY && k_ent && cursor_q == POS_MSD |=> state_q != ST_ENTRY)
    else $error("leading digit enter did not commit");
  chk_bad_pw: assert property ( // [R14]
    state_q == ST_ENTRY && commit && is_pw_q && !pw_ok |=> state_q == ST_RUN && denied_q)
    else $error("wrong password kept access");
  chk_menu_level: assert property ( // [R02]
    state_q == ST_ENTRY && commit && is_pw_q && pw_ok
    |=> state_q == ST_MENU && menu_q == $past(level_q) - 2'h1 && item_q == '0)
    else $error("menu does not match level");
  chk_setup_span: assert property ( // [R03]
    state_q == ST_RUN ##1 state_q == ST_LEVEL |-> setup_run_q == HOLD_W'(HOLD_CYCLES))
    else $error("level prompt opened before a full hold");
  chk_entry_preload: assert property ( // [R06]
    state_q == ST_MENU && k_ent && !k_up && !k_dn
    |=> state_q == ST_ENTRY && cursor_q == POS_LSD && !is_pw_q
        && disp_q == $past(par_q[menu_q][item_q]))
    else $error("entry not preloaded from stored value");
  chk_sign_range: assert property ( // [R10]
    disp_q.neg |-> disp_q.dig[POS_MSD] != DIG_MIN)
    else $error("negative zero in leading digit");
  chk_pair_commit: assert property ( // [R12]
    state_q == ST_ENTRY && both |=> state_q != ST_ENTRY)
    else $error("enter with reset did not commit");
  chk_store_menu: assert property ( // [R13]
    state_q == ST_ENTRY && commit && !is_pw_q |=> store_q && state_q == ST_MENU)
    else $error("committed value not stored");
  chk_item_forward: assert property ( // [R15]
    state_q == ST_MENU && k_dn && item_q != ITEM_LAST |=> item_q == $past(item_q) + 1'b1)
    else $error("down did not step item forward");
  chk_digit_clamp: assert property ( // [R16]
    state_q == ST_ENTRY && cursor_q != POS_MSD && !k_rst
    && ((k_up && disp_q.dig[cursor_q] == DIG_MAX)
        || (k_dn && !k_up && disp_q.dig[cursor_q] == DIG_MIN))
    |=> disp_q == $past(disp_q))
    else $error("digit wrapped past its limit");

endmodule : fpm_menu

// *** hdl/fpm_pkg.sv ***
package fpm_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned HOLD_TIME_MS = 1000;
  localparam int unsigned HOLD_CYCLES  = HOLD_TIME_MS * (CLK_HZ / 1000);

  // key positions on the pin bus
  localparam int unsigned KEY_N      = 6;
  localparam int unsigned KEY_SETUP  = 0;
  localparam int unsigned KEY_UP     = 1;
  localparam int unsigned KEY_DOWN   = 2;
  localparam int unsigned KEY_LIMITS = 3;
  localparam int unsigned KEY_ENTER  = 4;
  localparam int unsigned KEY_RESET  = 5;

  // five-digit number, digit 0 on the right, sign carried with digit 4
  localparam int unsigned DIGITS  = 5;
  localparam logic [2:0]  POS_LSD = 3'h0;
  localparam logic [2:0]  POS_MSD = 3'h4;
  localparam logic [3:0]  DIG_MAX = 4'h9;
  localparam logic [3:0]  DIG_MIN = 4'h0;

  typedef struct packed {
    logic                   neg;
    logic [DIGITS-1:0][3:0] dig;
  } fpm_num_t;

  localparam fpm_num_t NUM_ZERO = '{neg: 1'b0, dig: 20'h0_0000};

  // factory passwords
  localparam fpm_num_t PW_LEVEL_ONE_RST   = '{neg: 1'b0, dig: 20'h0_0001};
  localparam fpm_num_t PW_LEVEL_TWO_RST   = '{neg: 1'b0, dig: 20'h0_0002};
  localparam fpm_num_t PW_LEVEL_THREE_RST = '{neg: 1'b0, dig: 20'h0_0003};

  // user levels and menus
  localparam logic [1:0] LEVEL_ONE   = 2'h1;
  localparam logic [1:0] LEVEL_THREE = 2'h3;
  localparam logic [1:0] MENU_USER   = 2'h0;
  localparam logic [1:0] MENU_CAL    = 2'h1;
  localparam logic [1:0] MENU_CFG    = 2'h2;
  localparam int unsigned MENU_N     = 3;
  localparam int unsigned ITEMS      = 4;

  typedef enum logic [4:0] {
    ST_RUN   = 5'b0_0001,
    ST_LEVEL = 5'b0_0010,
    ST_ENTRY = 5'b0_0100,
    ST_MENU  = 5'b0_1000,
    ST_SPARE = 5'b1_0000
  } fpm_state_t;

endpackage : fpm_pkg

// *** testbench/fpm_menu_bench.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module fpm_menu_bench;
  import fpm_pkg::*;
  // short setup hold keeps the run brief
  localparam int unsigned HOLD = 20;
  localparam fpm_num_t    NEG9 = '{neg: 1'b1, dig: 20'h9_0000};
  localparam fpm_num_t    NEG91 = '{neg: 1'b1, dig: 20'h9_0001};

  logic                   sys_clk;
  logic                   rstn;
  logic [KEY_N-1:0]       key_pin_n;
  logic [4:0]             mode_q;
  logic [1:0]             level_q;
  fpm_num_t               disp_q;
  logic [2:0]             cursor_q;
  logic [1:0]             menu_q;
  logic [1:0]             item_q;
  logic                   store_q;
  logic                   denied_q;
  int                     bad_count;
  int                     n_compared;
  int                     n_store;
  int                     n_denied;

  fpm_menu #(.HOLD_CYCLES(HOLD), .ITEMS(ITEMS)) i_fpm_menu (
    .sys_clk(sys_clk), .rstn(rstn), .key_pin_n(key_pin_n), .mode_q(mode_q),
    .level_q(level_q), .disp_q(disp_q), .cursor_q(cursor_q), .menu_q(menu_q),
    .item_q(item_q), .store_q(store_q), .denied_q(denied_q));

  fpm_operator i_fpm_operator (.sys_clk(sys_clk), .key_pin_n(key_pin_n));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // event pulses are counted per cycle, so a stretched pulse shows as an extra count
  always @(posedge sys_clk) begin
    if (store_q === 1'b1) n_store++;
    if (denied_q === 1'b1) n_denied++;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // open the level prompt and step up to level lv
  task automatic go_level(input int unsigned lv);
    i_fpm_operator.hold(KEY_SETUP, 2 * HOLD);
    repeat (lv - 1) i_fpm_operator.push(KEY_UP);
  endtask : go_level

  task automatic t_reset();
    `CHK(mode_q, ST_RUN)
    `CHK(level_q, LEVEL_ONE)
    `CHK(disp_q, NUM_ZERO)
    `CHK({menu_q, item_q, cursor_q}, 7'h00)
  endtask : t_reset

  // two holds one cycle short do not add up; an exact full hold shows level one
  task automatic t_setup();
    repeat (2) i_fpm_operator.hold(KEY_SETUP, HOLD - 1);
    `CHK(mode_q, ST_RUN)
    i_fpm_operator.hold(KEY_SETUP, HOLD);
    `CHK(mode_q, ST_LEVEL)
    `CHK(level_q, LEVEL_ONE)
  endtask : t_setup

  // level stepping, digit limits, restart and a wrong password
  task automatic t_level_entry();
    i_fpm_operator.push(KEY_DOWN);
    `CHK(level_q, LEVEL_ONE)
    repeat (3) i_fpm_operator.push(KEY_UP);
    `CHK(level_q, LEVEL_THREE)
    i_fpm_operator.push(KEY_DOWN);
    `CHK(level_q, 2'h2)
    i_fpm_operator.push(KEY_LIMITS);
    `CHK({mode_q, level_q, cursor_q}, {ST_ENTRY, 2'h2, POS_LSD})
    `CHK(disp_q, NUM_ZERO)
    i_fpm_operator.push(KEY_DOWN);
    `CHK(disp_q, NUM_ZERO)
    repeat (10) i_fpm_operator.push(KEY_UP);
    `CHK(disp_q.dig, 20'h0_0009)
    i_fpm_operator.push(KEY_RESET);
    `CHK({disp_q, cursor_q}, {NUM_ZERO, POS_LSD})
    i_fpm_operator.push(KEY_UP);
    i_fpm_operator.push(KEY_ENTER);
    `CHK(cursor_q, 3'h1)
    repeat (2) i_fpm_operator.push(KEY_UP);
    `CHK(disp_q.dig, 20'h0_0021)
    i_fpm_operator.commit_pair();
    `CHK(mode_q, ST_RUN)
    `CHK(n_denied, 1)
  endtask : t_level_entry

  // each default password opens its own top menu at item 0
  task automatic t_access();
    for (int unsigned lv = 1; lv <= 3; lv++) begin
      go_level(lv);
      i_fpm_operator.push(KEY_LIMITS);
      repeat (lv) i_fpm_operator.push(KEY_UP);
      i_fpm_operator.commit_pair();
      `CHK({mode_q, menu_q, item_q}, {ST_MENU, 2'(lv - 1), 2'h0})
      if (lv < 3) i_fpm_operator.push(KEY_RESET);
    end
    `CHK({n_denied, n_store}, {32'd1, 32'd0})
  endtask : t_access

  // items, signed leading digit, both commit paths and stored preload
  task automatic t_items();
    i_fpm_operator.push(KEY_UP);
    `CHK(item_q, 2'h0)
    i_fpm_operator.push(KEY_DOWN);
    `CHK(item_q, 2'h1)
    i_fpm_operator.push(KEY_UP);
    i_fpm_operator.push(KEY_ENTER);
    `CHK({mode_q, disp_q, cursor_q}, {ST_ENTRY, NUM_ZERO, POS_LSD})
    repeat (4) i_fpm_operator.push(KEY_ENTER);
    `CHK(cursor_q, POS_MSD)
    i_fpm_operator.push(KEY_DOWN);
    `CHK(disp_q, fpm_num_t'({1'b1, 20'h1_0000}))
    i_fpm_operator.push(KEY_UP);
    `CHK(disp_q, NUM_ZERO)
    i_fpm_operator.push(KEY_DOWN);
    repeat (9) i_fpm_operator.push(KEY_DOWN);
    `CHK(disp_q, NEG9)
    i_fpm_operator.push(KEY_ENTER);
    `CHK({mode_q, item_q, n_store}, {ST_MENU, 2'h1, 32'd1})
    i_fpm_operator.push(KEY_UP);
    i_fpm_operator.push(KEY_ENTER);
    `CHK({disp_q, cursor_q}, {NEG9, POS_LSD})
    i_fpm_operator.push(KEY_UP);
    `CHK(disp_q, NEG91)
    i_fpm_operator.push(KEY_RESET);
    `CHK({disp_q, cursor_q}, {NEG9, POS_LSD})
    i_fpm_operator.commit_pair();
    `CHK({mode_q, item_q, n_store}, {ST_MENU, 2'h1, 32'd2})
    // past the last configuration item the walk flows into calibration and back
    repeat (3) i_fpm_operator.push(KEY_DOWN);
    `CHK({menu_q, item_q}, {MENU_CAL, 2'h0})
    i_fpm_operator.push(KEY_UP);
    `CHK({menu_q, item_q}, {MENU_CFG, 2'h3})
  endtask : t_items

  // main sequence
  initial begin
    rstn = 1'b0;
    bad_count = 0;
    n_compared = 0;
    n_store = 0;
    n_denied = 0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_setup();
    t_level_entry();
    t_access();
    t_items();
    end_sim();
  end

  // watchdog, well beyond the twelve hundred or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
endmodule : fpm_menu_bench

// *** testbench/fpm_operator.sv ***
`timescale 1ns/1ps
module fpm_operator (
  // clock
  input  wire logic                      sys_clk,
  // key pins, low while pressed, pulled high when released
  output logic [fpm_pkg::KEY_N-1:0]      key_pin_n
);
  import fpm_pkg::*;

  // all keys idle from time zero
  initial begin
    key_pin_n = '1;
  end

  // press one key for n cycles; n stays above the three-flop filter depth
  task automatic hold(input int unsigned k, input int unsigned n);
    @(posedge sys_clk) key_pin_n[k] <= 1'b0;
    repeat (n) @(posedge sys_clk);
    key_pin_n[k] <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : hold

  // a short tap, long enough for the filter to see it
  task automatic push(input int unsigned k);
    hold(k, 4);
  endtask : push

  // enter first, so reset is the later press and counts as the combined commit
  task automatic commit_pair();
    @(posedge sys_clk) key_pin_n[KEY_ENTER] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    key_pin_n[KEY_RESET] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    key_pin_n[KEY_ENTER] <= 1'b1;
    key_pin_n[KEY_RESET] <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask : commit_pair
endmodule : fpm_operator
